// [verilog/lbs_pkg.sv]
// shared constants of the led blink and status register bank
// assumes a 50 MHz system clock and a byte-wide register port
package lbs_pkg;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int TICK_PERIOD_NS = 1_000_000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int NUM_CH         = 3;
    localparam int NUM_FAULT      = 5;
    localparam int CUR_W          = 5;
    localparam int MS_W           = 14;

    localparam logic [2:0][7:0] ADDR_CURRENT = {8'h0f, 8'h0e, 8'h0d};
    localparam logic [2:0][7:0] ADDR_BLINK   = {8'h19, 8'h18, 8'h17};
    localparam logic [7:0] ADDR_SUPPLY     = 8'h1d;
    localparam logic [7:0] ADDR_CH_STATUS  = 8'h2d;
    localparam logic [7:0] ADDR_SYS_STATUS = 8'h2e;
    localparam logic [7:0] ADDR_DIE_ID     = 8'h39;
    localparam logic [7:0] ADDR_REV_ID     = 8'h3a;
    localparam logic [7:0] REG_RESET       = 8'h00;

    localparam int BLINK_EN_BIT = 6;
    localparam int OFF_LSB      = 3;
    localparam int ON_LSB       = 0;
    localparam int SUP_LSB      = 2;
    localparam int DIODE_BIT    = 2;
    localparam int THERM_BIT    = 1;
    localparam int OVERVOLT_BIT = 0;

    // phase lengths in ms
    localparam int ON_MS_00  = 256;
    localparam int ON_MS_01  = 512;
    localparam int ON_MS_10  = 1024;
    localparam int ON_MS_11  = 2048;
    localparam int OFF_MS_00 = 1024;
    localparam int OFF_MS_01 = 2048;
    localparam int OFF_MS_10 = 4096;
    localparam int OFF_MS_11 = 8192;

    function automatic logic [MS_W-1:0] on_ms(input logic [1:0] code);
        unique case (code)
            2'h0: return MS_W'(ON_MS_00);
            2'h1: return MS_W'(ON_MS_01);
            2'h2: return MS_W'(ON_MS_10);
            2'h3: return MS_W'(ON_MS_11);
        endcase
    endfunction

    function automatic logic [MS_W-1:0] off_ms(input logic [1:0] code);
        unique case (code)
            2'h0: return MS_W'(OFF_MS_00);
            2'h1: return MS_W'(OFF_MS_01);
            2'h2: return MS_W'(OFF_MS_10);
            2'h3: return MS_W'(OFF_MS_11);
        endcase
    endfunction
endpackage

// [verilog/lbs_if.sv]
// carriers between the register bank and its blink timers and status unit
// assumes all members are on the system clock
interface lbs_blink_if;
    logic       enable;
    logic [1:0] on_code;
    logic [1:0] off_code;
    logic       tick;
    logic       light;
    modport ctrl  (output enable, on_code, off_code, tick, input light);
    modport timer (input enable, on_code, off_code, tick, output light);
endinterface

interface lbs_stat_if;
    logic       rd_clear;
    logic [4:0] string_fault;
    logic       diode_missing;
    logic       thermal_flag;
    logic       overvoltage_flag;
    modport ctrl (output rd_clear,
                  input string_fault, diode_missing,
                  input thermal_flag, overvoltage_flag);
    modport stat (input rd_clear,
                  output string_fault, diode_missing,
                  output thermal_flag, overvoltage_flag);
endinterface

// [verilog/lbs_blink_timer.sv]
// one channel's blink on/off phase timer
// assumes a one-cycle ms tick from the bank's divider
module lbs_blink_timer (
    input  wire logic    i_clk_sys,
    input  wire logic    i_sys_rst,
    lbs_blink_if.timer   bl
);
    logic [lbs_pkg::MS_W-1:0] ms_count;
    logic [lbs_pkg::MS_W-1:0] phase_len;

    // a shortened code mid-phase ends the phase on the next ms tick, never wraps
    assign phase_len = bl.light ? lbs_pkg::on_ms(bl.on_code)
                                : lbs_pkg::off_ms(bl.off_code);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || !bl.enable) begin
            bl.light <= 1'b1;
            ms_count <= '0;
        end else if (bl.tick) begin
            if (ms_count >= phase_len - 1'b1) begin
                bl.light <= ~bl.light;
                ms_count <= '0;
            end else begin
                ms_count <= ms_count + 1'b1;
            end
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    chk_off_phase_len: assert property (
        $rose(bl.light) && bl.enable && $past(bl.enable) |->
        $past(ms_count) >= lbs_pkg::off_ms($past(bl.off_code)) - 1'b1)
        else $error("off phase ended early");
    chk_on_phase_len: assert property (
        $fell(bl.light) |->
        $past(ms_count) >= lbs_pkg::on_ms($past(bl.on_code)) - 1'b1)
        else $error("on phase ended early");
    chk_steady_when_off: assert property (
        !bl.enable |=> bl.light)
        else $error("light not steady with blink disabled");
endmodule

// [verilog/lbs_fault_status.sv]
// fault input synchronisers, live faults and sticky event flags
// assumes fault detector levels are asynchronous to the system clock
module lbs_fault_status (
    input  wire logic       i_clk_sys,
    input  wire logic       i_sys_rst,
    input  wire logic [4:0] i_string_fault,
    input  wire logic       i_diode_missing,
    input  wire logic       i_thermal_trip,
    input  wire logic       i_overvoltage,
    lbs_stat_if.stat        st
);
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [1:0] last_evt;
    logic [1:0] evt;
    logic [1:0] sticky;

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            sync1    <= '0;
            sync2    <= '0;
            last_evt <= '0;
        end else begin
            sync1    <= {i_overvoltage, i_thermal_trip,
                         i_diode_missing, i_string_fault};
            sync2    <= sync1;
            last_evt <= sync2[7:6];
        end
    end

    assign st.string_fault  = sync2[4:0];
    assign st.diode_missing = sync2[5];

    // entry into the protective state is the event, not the level
    for (genvar k = 0; k < 2; k++) begin : g_sticky
        assign evt[k] = sync2[6+k] & ~last_evt[k];
        always_ff @(posedge i_clk_sys) begin
            if (i_sys_rst) begin
                sticky[k] <= 1'b0;
            end else begin
                sticky[k] <= evt[k] | (sticky[k] & ~st.rd_clear);
            end
        end
    end

    assign st.thermal_flag     = sticky[0];
    assign st.overvoltage_flag = sticky[1];

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    chk_fault_live_sync: assert property (
        !$past(i_sys_rst) && !$past(i_sys_rst, 2) |->
        st.string_fault == $past(i_string_fault, 2))
        else $error("string fault not live");
    chk_diode_live_sync: assert property (
        !$past(i_sys_rst) && !$past(i_sys_rst, 2) |->
        st.diode_missing == $past(i_diode_missing, 2))
        else $error("diode flag not live");
    chk_thermal_set_hold: assert property (
        evt[0] || (st.thermal_flag && !st.rd_clear) |=> st.thermal_flag)
        else $error("thermal flag lost");
    chk_thermal_read_clr: assert property (
        st.rd_clear && !evt[0] |=> !st.thermal_flag)
        else $error("thermal flag not cleared by read");
    chk_overvolt_set_hold: assert property (
        evt[1] || (st.overvoltage_flag && !st.rd_clear) |=>
        st.overvoltage_flag)
        else $error("overvoltage flag lost");
    chk_overvolt_read_clr: assert property (
        st.rd_clear && !evt[1] |=> !st.overvoltage_flag)
        else $error("overvoltage flag not cleared by read");
endmodule

// [verilog/lbs_reg_bank.sv]
// register bank for the low-current channels: current, blink, supply,
// fault status and identification
// assumes the serial engine gives one-cycle read and write strobes
// with address and data valid in the same cycle
module lbs_reg_bank #(
    parameter int         TICK_CYCLES = lbs_pkg::TICK_CYCLES,
    parameter logic [7:0] DIE_ID      = 8'h42, // arbitrary value
    parameter logic [7:0] REV_ID      = 8'h31  // arbitrary value
) (
    input  wire logic            i_clk_sys,
    input  wire logic            i_sys_rst,
    input  wire logic [7:0]      i_reg_addr,
    input  wire logic [7:0]      i_reg_wdata,
    input  wire logic            i_reg_wr,
    input  wire logic            i_reg_rd,
    output logic      [7:0]      o_reg_rdata,
    input  wire logic [4:0]      i_string_fault,
    input  wire logic            i_diode_missing,
    input  wire logic            i_thermal_trip,
    input  wire logic            i_overvoltage,
    output logic      [2:0][4:0] o_sink_current_code,
    output logic      [2:0]      o_blink_enable,
    output logic      [2:0][1:0] o_blink_on_time,
    output logic      [2:0][1:0] o_blink_off_time,
    output logic      [2:0]      o_blink_light,
    output logic      [2:0]      o_supply_select
);
    localparam int N = lbs_pkg::NUM_CH;

    logic [15:0] tick_cnt;
    logic        tick;
    logic [7:0]  next_rdata;
    logic [2:0]  supply;

    lbs_stat_if st ();

    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] b);
        return a == b;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        for (int c = 0; c < N; c++) begin
            hit = hit | addr_hit(a, lbs_pkg::ADDR_CURRENT[c]) |
                  addr_hit(a, lbs_pkg::ADDR_BLINK[c]);
        end
        return hit | addr_hit(a, lbs_pkg::ADDR_SUPPLY) |
               addr_hit(a, lbs_pkg::ADDR_CH_STATUS) |
               addr_hit(a, lbs_pkg::ADDR_SYS_STATUS) |
               addr_hit(a, lbs_pkg::ADDR_DIE_ID) |
               addr_hit(a, lbs_pkg::ADDR_REV_ID);
    endfunction

    // ms tick; a divider keeps the per-channel counters narrow
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick     <= 1'b0;
        end
    end

    // all three channels live here, each with current, blink and timer; supply select is one shared register below
    for (genvar i = 0; i < N; i++) begin : g_ch
        logic [4:0] cur;
        logic       blink_en;
        logic [1:0] on_code;
        logic [1:0] off_code;

        always_ff @(posedge i_clk_sys) begin
            if (i_sys_rst) begin
                cur <= lbs_pkg::REG_RESET[4:0];
            end else if (i_reg_wr &&
                         addr_hit(i_reg_addr, lbs_pkg::ADDR_CURRENT[i])) begin
                cur <= i_reg_wdata[lbs_pkg::CUR_W-1:0];
            end
        end

        always_ff @(posedge i_clk_sys) begin
            if (i_sys_rst) begin
                blink_en <= 1'b0;
                on_code  <= 2'h0;
                off_code <= 2'h0;
            end else if (i_reg_wr &&
                         addr_hit(i_reg_addr, lbs_pkg::ADDR_BLINK[i])) begin
                blink_en <= i_reg_wdata[lbs_pkg::BLINK_EN_BIT];
                off_code <= i_reg_wdata[lbs_pkg::OFF_LSB +: 2];
                on_code  <= i_reg_wdata[lbs_pkg::ON_LSB +: 2];
            end
        end

        assign o_sink_current_code[i] = cur;
        assign o_blink_enable[i]      = blink_en;
        assign o_blink_on_time[i]     = on_code;
        assign o_blink_off_time[i]    = off_code;

        lbs_blink_if bl ();
        assign bl.enable   = blink_en;
        assign bl.on_code  = on_code;
        assign bl.off_code = off_code;
        assign bl.tick     = tick;
        assign o_blink_light[i] = bl.light;

        lbs_blink_timer u_timer (
            .i_clk_sys (i_clk_sys),
            .i_sys_rst (i_sys_rst),
            .bl        (bl.timer)
        );

        sequence s_blink_write;
            i_reg_wr && addr_hit(i_reg_addr, lbs_pkg::ADDR_BLINK[i]);
        endsequence

        sequence s_blink_read;
            i_reg_rd && !i_reg_wr &&
            addr_hit(i_reg_addr, lbs_pkg::ADDR_BLINK[i]);
        endsequence

        chk_blink_en_write: assert property (
            @(posedge i_clk_sys) disable iff (i_sys_rst)
            s_blink_write |=>
            o_blink_enable[i] == $past(i_reg_wdata[lbs_pkg::BLINK_EN_BIT]))
            else $error("blink enable not taken from write");
        chk_blink_codes: assert property (
            @(posedge i_clk_sys) disable iff (i_sys_rst)
            s_blink_write |=>
            o_blink_off_time[i] == $past(i_reg_wdata[4:3]) &&
            o_blink_on_time[i] == $past(i_reg_wdata[1:0]))
            else $error("blink time codes not taken from write");
        chk_current_write: assert property (
            @(posedge i_clk_sys) disable iff (i_sys_rst)
            i_reg_wr && addr_hit(i_reg_addr, lbs_pkg::ADDR_CURRENT[i])
            |=> o_sink_current_code[i] == $past(i_reg_wdata[4:0]))
            else $error("current code not taken from write");
        chk_current_read: assert property (
            @(posedge i_clk_sys) disable iff (i_sys_rst)
            i_reg_rd && !i_reg_wr &&
            addr_hit(i_reg_addr, lbs_pkg::ADDR_CURRENT[i])
            |=> o_reg_rdata == {3'h0, o_sink_current_code[i]})
            else $error("current register readback wrong");
        chk_blink_read: assert property (
            @(posedge i_clk_sys) disable iff (i_sys_rst)
            s_blink_read |=> o_reg_rdata == {1'b0, o_blink_enable[i], 1'b0,
                o_blink_off_time[i], 1'b0, o_blink_on_time[i]})
            else $error("blink register readback wrong");
        chk_light_steady: assert property (
            @(posedge i_clk_sys) disable iff (i_sys_rst)
            !o_blink_enable[i] |=> o_blink_light[i])
            else $error("light not steady with blink off");
        chk_light_start: assert property (
            @(posedge i_clk_sys) disable iff (i_sys_rst)
            $rose(o_blink_enable[i]) |-> o_blink_light[i])
            else $error("blink did not start in the on phase");
        chk_light_paced: assert property (
            @(posedge i_clk_sys) disable iff (i_sys_rst)
            $changed(o_blink_light[i]) |->
            $past(tick) || !$past(o_blink_enable[i]))
            else $error("light changed off the ms tick");
        chk_current_hold: assert property (
            @(posedge i_clk_sys) disable iff (i_sys_rst)
            !(i_reg_wr && addr_hit(i_reg_addr, lbs_pkg::ADDR_CURRENT[i]))
            |=> $stable(o_sink_current_code[i]))
            else $error("current code moved without a write");
        chk_blink_hold: assert property (
            @(posedge i_clk_sys) disable iff (i_sys_rst)
            !(i_reg_wr && addr_hit(i_reg_addr, lbs_pkg::ADDR_BLINK[i]))
            |=> $stable({o_blink_enable[i], o_blink_off_time[i],
                         o_blink_on_time[i]}))
            else $error("blink settings moved without a write");
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            supply <= lbs_pkg::REG_RESET[2:0];
        end else if (i_reg_wr &&
                     addr_hit(i_reg_addr, lbs_pkg::ADDR_SUPPLY)) begin
            supply <= i_reg_wdata[lbs_pkg::SUP_LSB +: N];
        end
    end

    // 1 = alternate supply, the converter loop ignores that channel
    assign o_supply_select = supply;

    lbs_fault_status u_status (
        .i_clk_sys       (i_clk_sys),
        .i_sys_rst       (i_sys_rst),
        .i_string_fault  (i_string_fault),
        .i_diode_missing (i_diode_missing),
        .i_thermal_trip  (i_thermal_trip),
        .i_overvoltage   (i_overvoltage),
        .st              (st.stat)
    );

    // the read strobe of status two is also its clear
    assign st.rd_clear = i_reg_rd &&
                         addr_hit(i_reg_addr, lbs_pkg::ADDR_SYS_STATUS);

    always_comb begin
        next_rdata = 8'h00;
        for (int c = 0; c < N; c++) begin
            if (addr_hit(i_reg_addr, lbs_pkg::ADDR_CURRENT[c])) begin
                next_rdata[4:0] = o_sink_current_code[c];
            end
            if (addr_hit(i_reg_addr, lbs_pkg::ADDR_BLINK[c])) begin
                next_rdata[lbs_pkg::BLINK_EN_BIT] = o_blink_enable[c];
                next_rdata[lbs_pkg::OFF_LSB +: 2] = o_blink_off_time[c];
                next_rdata[lbs_pkg::ON_LSB +: 2]  = o_blink_on_time[c];
            end
        end
        if (addr_hit(i_reg_addr, lbs_pkg::ADDR_SUPPLY)) begin
            next_rdata[lbs_pkg::SUP_LSB +: N] = supply;
        end
        if (addr_hit(i_reg_addr, lbs_pkg::ADDR_CH_STATUS)) begin
            next_rdata[lbs_pkg::NUM_FAULT-1:0] = st.string_fault;
        end
        if (addr_hit(i_reg_addr, lbs_pkg::ADDR_SYS_STATUS)) begin
            next_rdata[lbs_pkg::DIODE_BIT] = st.diode_missing;
            next_rdata[lbs_pkg::THERM_BIT] = st.thermal_flag;
            next_rdata[lbs_pkg::OVERVOLT_BIT] = st.overvoltage_flag;
        end
        if (addr_hit(i_reg_addr, lbs_pkg::ADDR_DIE_ID)) begin
            next_rdata = DIE_ID;
        end
        if (addr_hit(i_reg_addr, lbs_pkg::ADDR_REV_ID)) begin
            next_rdata = REV_ID;
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            o_reg_rdata <= next_rdata;
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    sequence s_read(logic [7:0] a);
        i_reg_rd && !i_reg_wr && addr_hit(i_reg_addr, a);
    endsequence

    chk_supply_read: assert property (
        s_read(lbs_pkg::ADDR_SUPPLY) |=>
        o_reg_rdata == {3'h0, o_supply_select, 2'h0})
        else $error("supply select readback wrong");
    chk_ch_status_read: assert property (
        s_read(lbs_pkg::ADDR_CH_STATUS) |=>
        o_reg_rdata == {3'h0, $past(st.string_fault)})
        else $error("channel fault status readback wrong");
    chk_sys_status_read: assert property (
        s_read(lbs_pkg::ADDR_SYS_STATUS) |=>
        o_reg_rdata == {5'h00, $past(st.diode_missing),
                        $past(st.thermal_flag),
                        $past(st.overvoltage_flag)})
        else $error("system fault status readback wrong");
    chk_sticky_read_clear: assert property (
        s_read(lbs_pkg::ADDR_SYS_STATUS) ##2
        s_read(lbs_pkg::ADDR_SYS_STATUS) and
        (!u_status.evt[0] [*3]) |=> !o_reg_rdata[lbs_pkg::THERM_BIT])
        else $error("thermal flag survived a read");
    chk_id_fixed: assert property (
        s_read(lbs_pkg::ADDR_DIE_ID) |=> o_reg_rdata == DIE_ID)
        else $error("die identifier changed");
    chk_rev_fixed: assert property (
        s_read(lbs_pkg::ADDR_REV_ID) |=> o_reg_rdata == REV_ID)
        else $error("revision identifier changed");
    chk_read_holds: assert property (
        !i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved without a read");
    // a divide-by-one setting leaves the tick high on every cycle
    chk_tick_spacing: assert property (
        tick |-> $past(tick_cnt) == 16'(TICK_CYCLES - 1))
        else $error("ms tick off its count");
    chk_tick_cnt_range: assert property (
        tick_cnt <= 16'(TICK_CYCLES - 1))
        else $error("ms divider ran past its count");
    chk_supply_write: assert property (
        i_reg_wr && addr_hit(i_reg_addr, lbs_pkg::ADDR_SUPPLY) |=>
        o_supply_select == $past(i_reg_wdata[lbs_pkg::SUP_LSB +: N]))
        else $error("supply select not taken from write");
    chk_supply_hold: assert property (
        !(i_reg_wr && addr_hit(i_reg_addr, lbs_pkg::ADDR_SUPPLY)) |=>
        $stable(o_supply_select))
        else $error("supply select moved without a write");
    chk_unmapped_zero: assert property (
        i_reg_rd && !is_mapped(i_reg_addr) |=> o_reg_rdata == 8'h00)
        else $error("unmapped address did not read zero");
endmodule

// [testbench/lbs_host_model.sv]
// partner model: serial host side issuing single-byte register strobes
// assumes the bench calls one task at a time; drives on falling edges
module lbs_host_model (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_reg_rdata,
    output logic      [7:0] o_reg_addr,
    output logic      [7:0] o_reg_wdata,
    output logic            o_reg_wr,
    output logic            o_reg_rd
);
    initial begin
        o_reg_addr  = 8'h00;
        o_reg_wdata = 8'h00;
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
    end

    // released lines show the inverse so a stale value is never trusted
    task automatic release_bus();
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_addr  = ~o_reg_addr;
        o_reg_wdata = ~o_reg_wdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_reg_addr  = a;
        o_reg_wdata = d;
        o_reg_wr    = 1'b1;
        @(negedge i_clk_sys);
        release_bus();
    endtask

    // read data holds until the next strobe, so the falling edge is safe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk_sys);
        o_reg_addr = a;
        o_reg_rd   = 1'b1;
        @(negedge i_clk_sys);
        release_bus();
        d = i_reg_rdata;
    endtask
endmodule

// [testbench/tb_led_driver_blink_status_regs.sv]
// self-checking bench of the blink, current, supply and status registers
// assumes the host model as bus partner and a 1-cycle ms tick
module tb_led_driver_blink_status_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] DIE_VAL = 8'h5a; // arbitrary value
    localparam logic [7:0] REV_VAL = 8'h3c; // arbitrary value
    localparam logic [7:0] ADDRS [13] = '{8'h0d, 8'h0e, 8'h0f, 8'h17,
        8'h18, 8'h19, 8'h1d, 8'h2d, 8'h2e, 8'h39, 8'h3a, 8'h00, 8'h3b};

    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic [7:0]      addr, wdata, rdata;
    logic            wr, rd;
    logic [4:0]      sf = 5'h00;
    logic            dm = 1'b0;
    logic            tt = 1'b0;
    logic            ov = 1'b0;
    logic [2:0][4:0] cur;
    logic [2:0]      ben, light, sup;
    logic [2:0][1:0] bon, boff;
    logic [7:0]      m_cur [3];
    logic [7:0]      m_blk [3];
    logic [7:0]      m_sup;
    logic            m_th, m_ov;
    logic [7:0]      rnd = 8'h11;
    int              err_count = 0;
    int              checks_done = 0;
    int              hi_n [3], lo_n [3], hi_len [3], lo_len [3];

    always #10 clk = ~clk;

    lbs_reg_bank #(.TICK_CYCLES(1), .DIE_ID(DIE_VAL), .REV_ID(REV_VAL)) dut (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_string_fault(sf), .i_diode_missing(dm),
        .i_thermal_trip(tt), .i_overvoltage(ov),
        .o_sink_current_code(cur), .o_blink_enable(ben),
        .o_blink_on_time(bon), .o_blink_off_time(boff),
        .o_blink_light(light), .o_supply_select(sup));

    lbs_host_model host (
        .i_clk_sys(clk), .i_reg_rdata(rdata), .o_reg_addr(addr),
        .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rd));

    // run lengths of each light phase, counted in clock cycles
    always @(negedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (light[i] === 1'b1) begin
                hi_n[i]++;
                if (lo_n[i] > 0) lo_len[i] = lo_n[i];
                lo_n[i] = 0;
            end else begin
                lo_n[i]++;
                if (hi_n[i] > 0) hi_len[i] = hi_n[i];
                hi_n[i] = 0;
            end
        end
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input string n, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        for (int i = 0; i < 3; i++) begin
            if (a == lbs_pkg::ADDR_CURRENT[i]) return m_cur[i];
            if (a == lbs_pkg::ADDR_BLINK[i]) return m_blk[i];
        end
        case (a)
            8'h1d: return m_sup;
            8'h2d: return {3'h0, sf};
            8'h2e: return {5'h00, dm, m_th, m_ov};
            8'h39: return DIE_VAL;
            8'h3a: return REV_VAL;
            default: return 8'h00;
        endcase
    endfunction

    // the model keeps only documented bits, reserved ones read zero
    task automatic do_wr(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        for (int i = 0; i < 3; i++) begin
            if (a == lbs_pkg::ADDR_CURRENT[i]) m_cur[i] = d & 8'h1f;
            if (a == lbs_pkg::ADDR_BLINK[i]) m_blk[i] = d & 8'h5b;
        end
        if (a == 8'h1d) m_sup = d & 8'h1c;
    endtask

    task automatic do_rd(input logic [7:0] a);
        logic [7:0] v;
        logic [7:0] e;
        e = exp_rd(a);
        host.rd(a, v);
        chk("rdata", 16'(v), 16'(e));
        if (a == 8'h2e) begin
            m_th = 1'b0;
            m_ov = 1'b0;
        end
    endtask

    task automatic chk_outs();
        for (int i = 0; i < 3; i++) begin
            chk("sink_code", 16'(cur[i]), 16'(m_cur[i][4:0]));
            chk("blink_en", 16'(ben[i]), 16'(m_blk[i][6]));
            chk("off_code", 16'(boff[i]), 16'(m_blk[i][4:3]));
            chk("on_code", 16'(bon[i]), 16'(m_blk[i][1:0]));
            chk("supply", 16'(sup[i]), 16'(m_sup[i+2]));
        end
    endtask

    task automatic conclude();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        conclude();
    end

    initial begin
        for (int i = 0; i < 3; i++) begin
            m_cur[i] = 8'h00;
            m_blk[i] = 8'h00;
        end
        m_sup = 8'h00;
        m_th = 1'b0;
        m_ov = 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        foreach (ADDRS[k]) do_rd(ADDRS[k]);
        // random writes everywhere, read-only and unmapped places too
        repeat (3) begin
            foreach (ADDRS[k]) begin
                rnd = lfsr_next(rnd);
                do_wr(ADDRS[k], rnd);
            end
            chk_outs();
            foreach (ADDRS[k]) do_rd(ADDRS[k]);
        end
        // live faults, then sticky events alone and together
        rnd = lfsr_next(rnd);
        @(negedge clk);
        sf = rnd[4:0];
        dm = 1'b1;
        repeat (3) @(negedge clk);
        do_rd(8'h2d);
        do_rd(8'h2e);
        for (int k = 1; k < 4; k++) begin
            @(negedge clk);
            {ov, tt} = 2'(k);
            m_th = tt;
            m_ov = ov;
            repeat (4) @(negedge clk);
            do_rd(8'h2e);
            do_rd(8'h2e);
            @(negedge clk);
            {ov, tt} = 2'h0;
            repeat (4) @(negedge clk);
        end
        // restart all timers so no stale phase skews the lengths
        for (int i = 0; i < 3; i++) do_wr(ADDRS[3+i], 8'h00);
        // on code 11 on all, off codes 01, 10 and 11
        do_wr(8'h17, 8'h4b);
        do_wr(8'h18, 8'h53);
        do_wr(8'h19, 8'h5b);
        chk_outs();
        repeat (10400) @(negedge clk);
        chk("on_len3", 16'(hi_len[0]), 16'(2048));
        chk("on_len4", 16'(hi_len[1]), 16'(2048));
        chk("off_len3", 16'(lo_len[0]), 16'(2048));
        chk("off_len4", 16'(lo_len[1]), 16'(4096));
        chk("off_len5", 16'(lo_len[2]), 16'(8192));
        for (int n = 0; n < 5000 && light[0] !== 1'b0; n++) @(negedge clk);
        chk("light_off", 16'(light[0]), 16'(0));
        do_wr(8'h17, 8'h00);
        @(negedge clk);
        chk("light_dis", 16'(light[0]), 16'(1));
        chk_outs();
        conclude();
    end
endmodule
